// File: hdl/lms_pkg.sv
// Package with constants, states and carrier types for the LED driver mode sequencer.
package lms_pkg;

  localparam int unsigned CLOCK_MHZ        = 200;
  localparam int unsigned STARTUP_DELAY_MS = 10;
  localparam int unsigned SOFT_START_MS    = 10;
  localparam int unsigned STARTUP_CYCLES   = STARTUP_DELAY_MS * 1000 * 1000 * CLOCK_MHZ / 1000;
  localparam int unsigned SOFT_START_CYCLES = SOFT_START_MS * 1000 * 1000 * CLOCK_MHZ / 1000;
  localparam int unsigned COUNT_WIDTH      = 24;

  localparam logic [7:0] SOFTWARE_RESET_ADDR = 8'h60;
  localparam logic [7:0] CONTROL_ADDR        = 8'h00;
  localparam int unsigned STANDBY_RELEASE_POS = 0;
  localparam int unsigned BOOST_ENABLE_POS    = 1;
  localparam logic [7:0] CONTROL_RESET        = 8'h00;

  typedef enum logic [4:0] {
    ST_RESET         = 5'b0_0001,
    ST_STANDBY       = 5'b0_0010,
    ST_STARTUP       = 5'b0_0100,
    ST_BOOST_STARTUP = 5'b0_1000,
    ST_NORMAL        = 5'b1_0000
  } lms_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } lms_write_t;

  typedef struct packed {
    logic chipEnable;
    logic boostRun;
    logic pulseFrequencyMode;
    logic ledBlank;
  } lms_power_t;

endpackage : lms_pkg

// File: hdl/lms_delay_timer.sv
// Cycle counter that reports when a fixed interval has elapsed since start.
`timescale 1ns/1ps
module lms_delay_timer #(
  parameter int unsigned CYCLES = 2000000
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic restart,
  input  wire logic run,
  output logic      done
);

  localparam logic [lms_pkg::COUNT_WIDTH-1:0] LAST = lms_pkg::COUNT_WIDTH'(CYCLES - 1);

  logic [lms_pkg::COUNT_WIDTH-1:0] count_reg;
  logic [lms_pkg::COUNT_WIDTH-1:0] count_next;
  wire                             atEnd = (count_reg == LAST);

  assign count_next = (restart || !run) ? '0 : (atEnd ? count_reg : count_reg + 1'b1);
  assign done       = run && !restart && atEnd;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule : lms_delay_timer

// File: hdl/lms_mode_sequencer.sv
// Operating-mode state machine of the LED driver: reset, standby, startup, boost soft start and normal.
//
// Contract
// - Reset loads defaults, then enters standby.
// - Standby-release bit clears to zero on reset.
// - Reset while pin low or power-on reset.
// - Any write to 0x60 resets the chip.
// - Power-on reset while second supply below threshold.
// - Standby whenever standby-release bit is zero.
// - Register writes accepted and stored in standby.
// - Startup waits 10 ms for oscillator.
// - Thermal shutdown holds chip in startup.
// - Boost soft-starts in pulse-frequency mode 10 ms.
// - Boost startup after startup or on enable.
// - LED outputs forced off during boost startup.
// - Control writes accepted in any order.
// - Boost stops when boost-enable written zero.
`timescale 1ns/1ps
module lms_mode_sequencer #(
  parameter int unsigned STARTUP_CYCLES    = lms_pkg::STARTUP_CYCLES,
  parameter int unsigned SOFT_START_CYCLES = lms_pkg::SOFT_START_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 reset_pin_n,
  input  wire logic                 second_supply_ok,
  input  wire logic                 thermal_shutdown,
  input  wire lms_pkg::lms_write_t  regWrite,
  input  wire logic [5:0]           ledRequest,
  output logic [5:0]                ledOut,
  output lms_pkg::lms_power_t       power,
  output lms_pkg::lms_state_t       mode,
  output logic [7:0]                controlValue
);

  lms_pkg::lms_state_t state_reg;
  lms_pkg::lms_state_t state_next;
  logic [7:0]          control_reg;
  logic [7:0]          control_next;
  logic                softReset_reg;
  logic                boostPrev_reg;
  lms_pkg::lms_power_t power_reg;
  lms_pkg::lms_power_t power_next;
  logic [5:0]          led_reg;
  logic [5:0]          led_next;

  // The software reset is registered for one cycle so the write that causes it completes cleanly.
  wire softResetHit = regWrite.valid && (regWrite.addr == lms_pkg::SOFTWARE_RESET_ADDR);
  wire resetActive  = sys_rst || !reset_pin_n || !second_supply_ok || softReset_reg;
  wire controlHit   = regWrite.valid && (regWrite.addr == lms_pkg::CONTROL_ADDR);
  wire standbyBit   = control_reg[lms_pkg::STANDBY_RELEASE_POS];
  wire boostBit     = control_reg[lms_pkg::BOOST_ENABLE_POS];
  wire boostRise    = boostBit && !boostPrev_reg;

  wire inStartup    = (state_reg == lms_pkg::ST_STARTUP);
  wire inBoost      = (state_reg == lms_pkg::ST_BOOST_STARTUP);
  wire startupDone;
  wire softDone;

  // Thermal shutdown clears the oscillator delay count to zero, so the full delay reruns once it clears.
  lms_delay_timer #(
    .CYCLES (STARTUP_CYCLES)
  ) startupTimer (
    .clock   (clock),
    .sys_rst (resetActive),
    .restart (thermal_shutdown),
    .run     (inStartup),
    .done    (startupDone)
  );

  lms_delay_timer #(
    .CYCLES (SOFT_START_CYCLES)
  ) softTimer (
    .clock   (clock),
    .sys_rst (resetActive),
    .restart (1'b0),
    .run     (inBoost && !thermal_shutdown),
    .done    (softDone)
  );

  assign control_next = controlHit ? regWrite.data : control_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      lms_pkg::ST_RESET:
        state_next = lms_pkg::ST_STANDBY;
      lms_pkg::ST_STANDBY:
        if (standbyBit)
          state_next = lms_pkg::ST_STARTUP;
      lms_pkg::ST_STARTUP:
        if (!standbyBit)
          state_next = lms_pkg::ST_STANDBY;
        else if (startupDone && boostBit)
          state_next = lms_pkg::ST_BOOST_STARTUP;
        else if (startupDone)
          state_next = lms_pkg::ST_NORMAL;
      lms_pkg::ST_BOOST_STARTUP:
        if (!standbyBit)
          state_next = lms_pkg::ST_STANDBY;
        else if (thermal_shutdown)
          state_next = lms_pkg::ST_STARTUP;
        else if (!boostBit)
          state_next = lms_pkg::ST_NORMAL;
        else if (softDone)
          state_next = lms_pkg::ST_NORMAL;
      lms_pkg::ST_NORMAL:
        if (!standbyBit)
          state_next = lms_pkg::ST_STANDBY;
        else if (thermal_shutdown)
          state_next = lms_pkg::ST_STARTUP;
        else if (boostRise)
          state_next = lms_pkg::ST_BOOST_STARTUP;
      default:
        state_next = lms_pkg::ST_RESET;
    endcase
  end

  wire nextBoost  = (state_next == lms_pkg::ST_BOOST_STARTUP);
  wire nextNormal = (state_next == lms_pkg::ST_NORMAL);

  always_comb
  begin
    power_next.chipEnable         = nextBoost || nextNormal;
    power_next.boostRun           = (nextBoost || nextNormal) && boostBit;
    power_next.pulseFrequencyMode = nextBoost;
    power_next.ledBlank           = nextBoost;
  end

  // LED outputs follow the request only in normal mode; blanking during soft start avoids a current surge.
  assign led_next = nextNormal ? ledRequest : 6'h0;

  always_ff @(posedge clock)
  begin
    if (resetActive)
    begin
      state_reg     <= lms_pkg::ST_RESET;
      control_reg   <= lms_pkg::CONTROL_RESET;
      boostPrev_reg <= 1'b0;
      power_reg     <= '0;
      led_reg       <= 6'h0;
    end
    else
    begin
      state_reg     <= state_next;
      control_reg   <= control_next;
      boostPrev_reg <= boostBit;
      power_reg     <= power_next;
      led_reg       <= led_next;
    end
  end

  // Held by sys_rst only, so the pulse clears itself one cycle after the write.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      softReset_reg <= 1'b0;
    else
      softReset_reg <= softResetHit && !softReset_reg;
  end

  assign mode         = state_reg;
  assign power        = power_reg;
  assign ledOut       = led_reg;
  assign controlValue = control_reg;

endmodule : lms_mode_sequencer

// File: bench/lms_assertions.sv
// Checker of the mode sequencer port rules.
`timescale 1ns/1ps
module lms_assertions #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                reset_pin_n,
  input wire logic                second_supply_ok,
  input wire logic                thermal_shutdown,
  input wire lms_pkg::lms_write_t regWrite,
  input wire logic [5:0]          ledOut,
  input wire lms_pkg::lms_power_t power,
  input wire lms_pkg::lms_state_t mode,
  input wire logic [7:0]          controlValue
);
  lms_pkg::lms_state_t modeQ;
  int unsigned         dwell;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Thermal clears the count because the startup delay restarts while it is present.
  always_ff @(posedge clock)
  begin
    modeQ <= mode;
    dwell <= (mode != modeQ || thermal_shutdown) ? 0 : dwell + 1;
  end
  AST_PIN: assert property (!reset_pin_n |=> mode == lms_pkg::ST_RESET && controlValue == 8'h00)
    else $error("pin reset missed");
  AST_POR: assert property (!second_supply_ok |=> mode == lms_pkg::ST_RESET)
    else $error("supply reset missed");
  AST_SOFT: assert property (regWrite.valid && regWrite.addr == 8'h60 && mode != lms_pkg::ST_RESET
    |-> ##[1:2] mode == lms_pkg::ST_RESET) else $error("soft reset missed");
  AST_REL: assert property (mode == lms_pkg::ST_RESET ##1 mode != lms_pkg::ST_RESET
    |-> mode == lms_pkg::ST_STANDBY) else $error("no standby after reset");
  AST_STBY: assert property (!controlValue[0] ##1 !controlValue[0] |-> !power.chipEnable
    && mode inside {lms_pkg::ST_STANDBY, lms_pkg::ST_RESET}) else $error("not in standby");
  AST_DELAY: assert property (modeQ == lms_pkg::ST_STARTUP && mode inside {lms_pkg::ST_BOOST_STARTUP,
    lms_pkg::ST_NORMAL} |-> dwell + 2 >= STARTUP_CYCLES && dwell <= STARTUP_CYCLES) else $error("startup length");
  AST_BLANK: assert property (mode == lms_pkg::ST_BOOST_STARTUP |-> ledOut == 6'h00
    && power.ledBlank && power.pulseFrequencyMode) else $error("soft start outputs");
  AST_TSD: assert property (thermal_shutdown [*2] |-> !(mode inside {lms_pkg::ST_BOOST_STARTUP,
    lms_pkg::ST_NORMAL})) else $error("running in thermal shutdown");
  COV_BOOST: cover property (mode == lms_pkg::ST_BOOST_STARTUP);
  COV_TSD: cover property (thermal_shutdown && mode == lms_pkg::ST_STARTUP);
  COV_SOFT: cover property (regWrite.valid && regWrite.addr == 8'h60);
endmodule : lms_assertions
bind lms_mode_sequencer lms_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) checker_i (.clock(clock),
  .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .second_supply_ok(second_supply_ok), .regWrite(regWrite),
  .thermal_shutdown(thermal_shutdown), .ledOut(ledOut), .power(power), .mode(mode), .controlValue(controlValue));

// File: bench/lms_host_model.sv
// Host writer that turns a request into one registered write strobe.
`timescale 1ns/1ps
module lms_host_model (
  input  wire logic                clock,
  input  wire lms_pkg::lms_write_t request,
  output lms_pkg::lms_write_t      regWrite
);
  always_ff @(posedge clock)
  begin
    regWrite <= request;
  end
endmodule : lms_host_model

// File: bench/lms_mode_sequencer_bench.sv
// Self-checking bench of the mode sequencer.
`timescale 1ns/1ps
module lms_mode_sequencer_bench;
  logic                clock = 1'b0;
  logic                sys_rst = 1'b1;
  logic                pinN = 1'b1;
  logic                supplyOk = 1'b1;
  logic                thermal = 1'b0;
  lms_pkg::lms_write_t request = '0;
  lms_pkg::lms_write_t regWrite;
  lms_pkg::lms_power_t power;
  lms_pkg::lms_state_t mode;
  logic [5:0]          ledOut;
  logic [7:0]          controlValue;
  int                  error_cnt = 0;
  int                  checks_done = 0;
  int                  cycles = 0;
  int                  n;
  logic [7:0]          rowData [5] = '{8'h00, 8'h01, 8'h03, 8'h01, 8'h03};
  logic                rowRun [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  always #2.5 clock = ~clock;
  lms_host_model host (.clock(clock), .request(request), .regWrite(regWrite));
  lms_mode_sequencer #(.STARTUP_CYCLES(20), .SOFT_START_CYCLES(20)) dut (.clock(clock), .sys_rst(sys_rst),
    .reset_pin_n(pinN), .second_supply_ok(supplyOk), .thermal_shutdown(thermal), .regWrite(regWrite),
    .ledRequest(6'h2A), .ledOut(ledOut), .power(power), .mode(mode), .controlValue(controlValue));
  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input bit ok);
    checks_done++;
    if (!ok)
      $display("ERROR %0t mismatch %0d", $time, ++error_cnt);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    request <= '{1'b1, a, d};
    @(posedge clock);
    request <= '0;
  endtask : wr
  task automatic idle(input int c);
    repeat (c) @(posedge clock);
  endtask : idle
  always @(posedge clock)
    if (++cycles == 3000)
    begin
      error_cnt++;
      summarize();
    end
  initial
  begin
    idle(8);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h00, rowData[i]);
      idle(60);
      chk(mode === (rowRun[i] ? lms_pkg::ST_NORMAL : lms_pkg::ST_STANDBY));
      chk(controlValue === rowData[i] && power.boostRun === (rowRun[i] & rowData[i][1]));
      chk(power.chipEnable === rowRun[i] && power.pulseFrequencyMode === 1'b0);
      chk(ledOut === (rowRun[i] ? 6'h2A : 6'h00));
    end
    wr(8'h00, 8'h02);
    idle(4);
    wr(8'h00, 8'h03);
    for (n = 0; mode !== lms_pkg::ST_BOOST_STARTUP && n < 99; n++)
      idle(1);
    chk(n >= 19 && n <= 23);
    chk(power.pulseFrequencyMode === 1'b1 && power.ledBlank === 1'b1 && ledOut === 6'h00);
    for (n = 0; mode === lms_pkg::ST_BOOST_STARTUP && n < 99; n++)
      idle(1);
    chk(mode === lms_pkg::ST_NORMAL && n >= 19 && n <= 21);
    thermal <= 1'b1;
    idle(40);
    chk(mode === lms_pkg::ST_STARTUP);
    thermal <= 1'b0;
    idle(60);
    chk(mode === lms_pkg::ST_NORMAL);
    wr(8'h33, 8'hFF);
    idle(3);
    chk(mode === lms_pkg::ST_NORMAL && controlValue === 8'h03);
    wr(8'h60, 8'h5A);
    idle(6);
    chk(mode === lms_pkg::ST_STANDBY && controlValue === 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, 8'h01);
      pinN <= i[0];
      supplyOk <= !i[0];
      idle(3);
      chk(mode === lms_pkg::ST_RESET && controlValue === 8'h00);
      pinN <= 1'b1;
      supplyOk <= 1'b1;
      idle(2);
      chk(mode === lms_pkg::ST_STANDBY);
    end
    summarize();
  end
endmodule : lms_mode_sequencer_bench
